/* File: fracn_accum_stage.sv */
// one modulo accumulator stage of the delta-sigma modulator
// assumes its input is already below the denominator and all signals share clock_i
`timescale 1ns/1ps
`default_nettype none
`include "fracn_cfg.svh"

module fracn_accum_stage #(
    parameter int FRAC_W = `FRAC_W
) (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic              clear_i,
    input  wire logic              step_i,
    input  wire logic [FRAC_W-1:0] den_i,
    input  wire logic [FRAC_W-1:0] in_i,
    output var  logic [FRAC_W-1:0] residue_o,
    output var  logic              carry_o
);

    if (FRAC_W < 2 || FRAC_W > 30) begin : g_bad_width
        $error("fracn_accum_stage: FRAC_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sum and wrap at the denominator
    logic [FRAC_W:0] sum_w;
    logic            wrap_w;
    logic [FRAC_W:0] wrapped_w;
    assign sum_w     = {1'b0, residue_o} + {1'b0, in_i};
    assign wrap_w    = (sum_w >= {1'b0, den_i});
    assign wrapped_w = wrap_w ? (sum_w - {1'b0, den_i}) : sum_w;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || clear_i) begin
            residue_o <= '0;
            carry_o   <= 1'b0;
        end else if (step_i) begin
            residue_o <= wrapped_w[FRAC_W-1:0];
            carry_o   <= wrap_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // residue stays below the denominator while the input does
    a_residue_bound: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (step_i && !clear_i && in_i < den_i && residue_o < den_i && $stable(den_i))
            |=> (residue_o < $past(den_i)))
        else $error("accumulator residue reached the denominator");

endmodule
`default_nettype wire

/* File: fracn_cfg.svh */
// constants of the fractional-n divider control block: offsets, fields, resets, limits
// assumes a 32-bit apb register bus with byte addresses in the low eight bits
`ifndef FRACN_CFG_SVH
`define FRACN_CFG_SVH

// register byte offsets
`define OFS_PRIMARY   8'h00
`define OFS_NUMER     8'h04
`define OFS_DENOM     8'h08
`define OFS_MODCTL    8'h0C
`define OFS_REFPATH   8'h10
`define OFS_OUTDIV    8'h14
`define OFS_CALSTART  8'h18
`define OFS_STATUS    8'h1C

// widths
`define INT_W         16
`define FRAC_W        22
`define DIV_W         17

// field positions
`define ORDER_LSB     0
`define DITHER_LSB    2
`define DOUBLER_BIT   0
`define RDIV_LSB      8
`define REFSET_LSB    16
`define PFDDLY_LSB    24
`define CORE_LSB      0
`define CAP_LSB       8
`define DONE_BIT      16
`define BUSY_BIT      17

// reset values
`define INT_RST       16'h0064
`define NUMER_RST     22'h000000
`define DENOM_RST     22'h000001
`define RDIV_RST      8'h01
`define REFSET_RST    8'h10
`define OUTDIV_RST    6'h01
`define CORE_RST      3'h3
`define CAP_RST       7'h7F
`define LFSR_SEED     16'hACE1

// calibration limits
`define CORE_MIN      3'h1
`define CORE_MAX      3'h4
`define CAP_MAX       7'h7F

`endif

/* File: fracn_pkg.sv */
// types shared by the fractional-n divider control block
// assumes fracn_cfg.svh is on the include path
`include "fracn_cfg.svh"

package fracn_pkg;

    typedef enum logic [1:0] {ORDER_INT, ORDER_ONE, ORDER_TWO, ORDER_THREE} mod_order_t;
    typedef enum logic [1:0] {DITHER_OFF, DITHER_WEAK, DITHER_MEDIUM, DITHER_STRONG}
        dither_level_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_DONE} cal_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic [2:0]    detector_delay_setting;
        logic [5:0]    output_divide_value;
        logic [7:0]    reference_frequency_setting;
        logic [7:0]    reference_divide;
        logic          reference_doubler_select;
        mod_order_t    order;
        dither_level_t dither;
    } synth_cfg_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic [2:0] core;
        logic [6:0] tuning_capacitor_code;
    } cal_status_t;

endpackage

/* File: fractional_n_divider_control.sv */
// fractional-n feedback divider control: apb registers, mash modulator, dither,
// reference path settings and oscillator band calibration start
// assumes divider_tick_i is a one-cycle pulse on clock_i per feedback divider cycle;
// reference_input_i and vco_fast_i are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "fracn_cfg.svh"

module fractional_n_divider_control (
    input  wire logic                    clock_i,
    input  wire logic                    sys_rst_i,
    input  wire fracn_pkg::apb_req_t     apb_i,
    output var  fracn_pkg::apb_rsp_t     apb_o,
    input  wire logic                    divider_tick_i,
    input  wire logic                    reference_input_i,
    input  wire logic                    vco_fast_i,
    output var  logic [`DIV_W-1:0]       divide_value_o,
    output var  fracn_pkg::synth_cfg_t   synth_cfg_o,
    output var  fracn_pkg::cal_status_t  cal_status_o
);
    import fracn_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [7:0] dither_mask(input dither_level_t lvl);
        return (lvl == DITHER_OFF)  ? 8'h00 :
               (lvl == DITHER_WEAK) ? 8'h01 :
               (lvl == DITHER_MEDIUM) ? 8'h0F : 8'hFF;
    endfunction

    logic [`INT_W-1:0]  int_reg;
    logic [`FRAC_W-1:0] num_reg;
    logic [`FRAC_W-1:0] den_reg;
    logic [2:0]         start_core_reg;
    logic [6:0]         start_cap_reg;

    wire        access_w  = apb_i.psel & apb_i.penable;
    wire        ack_w     = access_w & ~apb_o.pready;      // one wait state
    wire        commit_w  = access_w & apb_o.pready & apb_i.pwrite;
    wire [7:0]  addr_w    = apb_i.paddr;
    wire [31:0] wd_w      = apb_i.pwdata;
    wire wr_primary_w     = commit_w & hit(addr_w, `OFS_PRIMARY);
    wire wr_num_w         = commit_w & hit(addr_w, `OFS_NUMER);
    wire wr_den_w         = commit_w & hit(addr_w, `OFS_DENOM);
    wire wr_mod_w         = commit_w & hit(addr_w, `OFS_MODCTL);
    wire wr_ref_w         = commit_w & hit(addr_w, `OFS_REFPATH);
    wire wr_outdiv_w      = commit_w & hit(addr_w, `OFS_OUTDIV);
    wire wr_cal_w         = commit_w & hit(addr_w, `OFS_CALSTART);
    wire mapped_w = hit(addr_w, `OFS_PRIMARY) | hit(addr_w, `OFS_NUMER) |
                    hit(addr_w, `OFS_DENOM) | hit(addr_w, `OFS_MODCTL) |
                    hit(addr_w, `OFS_REFPATH) | hit(addr_w, `OFS_OUTDIV) |
                    hit(addr_w, `OFS_CALSTART) | hit(addr_w, `OFS_STATUS);

    // read selection
    wire [31:0] rd_w =
        hit(addr_w, `OFS_PRIMARY)  ? {16'h0000, int_reg} :
        hit(addr_w, `OFS_NUMER)    ? {10'h000, num_reg} :
        hit(addr_w, `OFS_DENOM)    ? {10'h000, den_reg} :
        hit(addr_w, `OFS_MODCTL)   ? {28'h0000000, synth_cfg_o.dither, synth_cfg_o.order} :
        hit(addr_w, `OFS_REFPATH)  ? {5'h00, synth_cfg_o.detector_delay_setting,
                                      synth_cfg_o.reference_frequency_setting,
                                      synth_cfg_o.reference_divide, 7'h00,
                                      synth_cfg_o.reference_doubler_select} :
        hit(addr_w, `OFS_OUTDIV)   ? {26'h0000000, synth_cfg_o.output_divide_value} :
        hit(addr_w, `OFS_CALSTART) ? {17'h00000, start_cap_reg, 5'h00, start_core_reg} :
        hit(addr_w, `OFS_STATUS)   ? {14'h0000, cal_status_o.busy, cal_status_o.done,
                                      1'b0, cal_status_o.tuning_capacitor_code,
                                      5'h00, cal_status_o.core} : 32'h00000000;

    // bus answer
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            apb_o <= '0;
        end else begin
            apb_o.pready  <= ack_w;
            apb_o.pslverr <= ack_w & ~mapped_w;
            apb_o.prdata  <= (ack_w & ~apb_i.pwrite) ? rd_w : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software set divide terms
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            int_reg <= `INT_RST;
            num_reg <= `NUMER_RST;
            den_reg <= `DENOM_RST;
        end else begin
            if (wr_primary_w) int_reg <= wd_w[`INT_W-1:0];
            if (wr_num_w)     num_reg <= wd_w[`FRAC_W-1:0];
            if (wr_den_w)     den_reg <= wd_w[`FRAC_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            synth_cfg_o <= '{detector_delay_setting: 3'h0, output_divide_value: `OUTDIV_RST,
                             reference_frequency_setting: `REFSET_RST,
                             reference_divide: `RDIV_RST, reference_doubler_select: 1'b0,
                             order: ORDER_INT, dither: DITHER_OFF};
        end else begin
            if (wr_mod_w) begin
                synth_cfg_o.order  <= mod_order_t'(wd_w[`ORDER_LSB +: 2]);
                synth_cfg_o.dither <= dither_level_t'(wd_w[`DITHER_LSB +: 2]);
            end
            if (wr_ref_w) begin
                synth_cfg_o.reference_doubler_select    <= wd_w[`DOUBLER_BIT];
                synth_cfg_o.reference_divide            <= wd_w[`RDIV_LSB +: 8];
                synth_cfg_o.reference_frequency_setting <= wd_w[`REFSET_LSB +: 8];
                synth_cfg_o.detector_delay_setting      <= wd_w[`PFDDLY_LSB +: 3];
            end
            if (wr_outdiv_w) synth_cfg_o.output_divide_value <= wd_w[5:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            start_core_reg <= `CORE_RST;
            start_cap_reg  <= `CAP_RST;
        end else if (wr_cal_w) begin
            start_core_reg <= wd_w[`CORE_LSB +: 3];
            start_cap_reg  <= wd_w[`CAP_LSB +: 7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // zero denominator acts as one
    wire [`FRAC_W-1:0] den_eff_w = (den_reg == '0) ? `DENOM_RST : den_reg;

    // dither lfsr, reseeded with the modulator
    logic [15:0] lfsr_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || wr_primary_w) lfsr_reg <= `LFSR_SEED;
        else if (divider_tick_i) lfsr_reg <= {lfsr_reg[14:0],
                                              lfsr_reg[15] ^ lfsr_reg[13] ^
                                              lfsr_reg[12] ^ lfsr_reg[10]};
    end
    wire [7:0]         dith_w   = lfsr_reg[7:0] & dither_mask(synth_cfg_o.dither);
    wire [`FRAC_W:0]   dsum_w   = {1'b0, num_reg} + {15'h0000, dith_w};
    // dither only where the input stays below the denominator
    wire               dok_w    = dsum_w < {1'b0, den_eff_w};

    logic [`FRAC_W-1:0] stage_in_w [3];
    logic [`FRAC_W-1:0] residue_w  [3];
    logic [2:0]         carry_w;
    assign stage_in_w[0] = dok_w ? dsum_w[`FRAC_W-1:0] : num_reg;
    for (genvar k = 0; k < 3; k++) begin : g_stage
        if (k > 0) begin : g_chain
            assign stage_in_w[k] = residue_w[k-1];
        end
        fracn_accum_stage #(.FRAC_W(`FRAC_W)) u_stage (
            .clock_i   (clock_i),
            .sys_rst_i (sys_rst_i),
            .clear_i   (wr_primary_w),
            .step_i    (divider_tick_i),
            .den_i     (den_eff_w),
            .in_i      (stage_in_w[k]),
            .residue_o (residue_w[k]),
            .carry_o   (carry_w[k])
        );
    end

    logic c2d_reg;
    logic c3d_reg;
    logic c3dd_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || wr_primary_w) begin
            c2d_reg  <= 1'b0;
            c3d_reg  <= 1'b0;
            c3dd_reg <= 1'b0;
        end else if (divider_tick_i) begin
            c2d_reg  <= carry_w[1];
            c3d_reg  <= carry_w[2];
            c3dd_reg <= c3d_reg;
        end
    end

    wire signed [3:0] t1_w  = {3'b000, carry_w[0]};
    wire signed [3:0] t2_w  = {3'b000, carry_w[1]} - {3'b000, c2d_reg};
    wire signed [3:0] t3_w  = {3'b000, carry_w[2]} - {2'b00, c3d_reg, 1'b0}
                            + {3'b000, c3dd_reg};
    wire signed [3:0] off_w =
        (synth_cfg_o.order == ORDER_INT) ? 4'sh0 :
        (synth_cfg_o.order == ORDER_ONE) ? t1_w :
        (synth_cfg_o.order == ORDER_TWO) ? t1_w + t2_w : t1_w + t2_w + t3_w;
    wire [`DIV_W-1:0] div_next_w = {1'b0, int_reg} + {{(`DIV_W-4){off_w[3]}}, off_w};

    // feedback term of the output frequency
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) divide_value_o <= {1'b0, `INT_RST};
        else if (wr_primary_w) divide_value_o <= {1'b0, wd_w[`INT_W-1:0]};
        else if (divider_tick_i) divide_value_o <= div_next_w;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 0 reference, bit 1 comparator
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] lvl_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
            lvl_reg   <= 2'h0;
        end else begin
            sync1_reg <= {vco_fast_i, reference_input_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg   <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
                         (lvl_reg & (sync2_reg ^ sync3_reg));
        end
    end
    wire ref_rise_w = sync2_reg[0] & sync3_reg[0] & ~lvl_reg[0];
    wire step_up_w  = ~lvl_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // band calibration search
    cal_state_t  cal_state_reg;
    logic [7:0]  win_reg;
    logic        dir_reg;
    logic        first_reg;
    wire win_end_w = (cal_state_reg == CAL_MEASURE) & ref_rise_w &
                     (win_reg == synth_cfg_o.reference_frequency_setting);
    wire turn_w    = ~first_reg & (step_up_w != dir_reg);
    wire top_w     = (cal_status_o.tuning_capacitor_code == `CAP_MAX);
    wire bot_w     = (cal_status_o.tuning_capacitor_code == 7'h00);
    wire stop_w    = turn_w | (step_up_w ? (top_w & cal_status_o.core >= `CORE_MAX)
                                         : (bot_w & cal_status_o.core <= `CORE_MIN));

    // search begins at chosen core and code
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cal_state_reg <= CAL_IDLE;
            cal_status_o  <= '{busy: 1'b0, done: 1'b0, core: `CORE_RST,
                               tuning_capacitor_code: `CAP_RST};
            win_reg       <= 8'h00;
            dir_reg       <= 1'b0;
            first_reg     <= 1'b1;
        end else if (wr_primary_w) begin
            cal_state_reg <= CAL_MEASURE;
            cal_status_o  <= '{busy: 1'b1, done: 1'b0, core: start_core_reg,
                               tuning_capacitor_code: start_cap_reg};
            win_reg       <= 8'h00;
            first_reg     <= 1'b1;
        end else if (win_end_w) begin
            win_reg   <= 8'h00;
            dir_reg   <= step_up_w;
            first_reg <= 1'b0;
            if (stop_w) begin
                cal_state_reg     <= CAL_DONE;
                cal_status_o.busy <= 1'b0;
                cal_status_o.done <= 1'b1;
            end else if (step_up_w) begin
                cal_status_o.tuning_capacitor_code <= top_w ? 7'h00 :
                    cal_status_o.tuning_capacitor_code + 7'h01;
                if (top_w) cal_status_o.core <= cal_status_o.core + 3'h1;
            end else begin
                cal_status_o.tuning_capacitor_code <= bot_w ? `CAP_MAX :
                    cal_status_o.tuning_capacitor_code - 7'h01;
                if (bot_w) cal_status_o.core <= cal_status_o.core - 3'h1;
            end
        end else if (cal_state_reg == CAL_MEASURE && ref_rise_w) begin
            win_reg <= win_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_primary_clears: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        wr_primary_w |=> (residue_w[0] == '0 && residue_w[2] == '0 && !c3d_reg && !c2d_reg))
        else $error("modulator state not cleared by primary write");
    a_cal_starts: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        wr_primary_w |=> (cal_status_o.busy && !cal_status_o.done &&
                          cal_state_reg == CAL_MEASURE))
        else $error("calibration did not start on primary write");
    a_cal_origin: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        wr_primary_w |=> (cal_status_o.core == $past(start_core_reg) &&
                          cal_status_o.tuning_capacitor_code == $past(start_cap_reg)))
        else $error("calibration did not begin at the chosen start point");
    a_integer_mode: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (divider_tick_i && !wr_primary_w && synth_cfg_o.order == ORDER_INT)
            |=> (divide_value_o == {1'b0, $past(int_reg)}))
        else $error("integer mode divide differs from integer part");
    a_first_order: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (divider_tick_i && !wr_primary_w && synth_cfg_o.order == ORDER_ONE)
            |=> (divide_value_o == {1'b0, $past(int_reg)} + {16'h0000, $past(carry_w[0])}))
        else $error("first order divide is not integer plus carry");
    a_dither_off: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (synth_cfg_o.dither == DITHER_OFF) |-> (stage_in_w[0] == num_reg))
        else $error("dither applied while switched off");
    a_den_floor: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        wr_den_w ##1 (den_reg == '0) |-> (den_eff_w == `DENOM_RST))
        else $error("zero denominator not treated as one");
    a_ref_path: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (wr_ref_w && wd_w[`DOUBLER_BIT] && wd_w[`RDIV_LSB +: 8] != 8'h00)
            |=> (synth_cfg_o.reference_doubler_select && synth_cfg_o.reference_divide != 8'h00))
        else $error("doubler and divider not both enabled");
    a_bus_answer: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        ack_w |=> (apb_o.pready ##1 !apb_o.pready))
        else $error("bus answer not a single cycle after one wait state");

endmodule
`default_nettype wire

/* File: tb_fractional_n_divider_control.sv */
// testbench of the fractional-n divider control block
// assumes the design files and fracn_cfg.svh are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "fracn_cfg.svh"

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module tb_fractional_n_divider_control;
    import fracn_pkg::*;
    logic        clock_i, sys_rst_i, divider_tick_i, reference_input_i, vco_fast_i;
    apb_req_t    apb_i;
    apb_rsp_t    apb_o;
    logic [16:0] divide_value_o;
    synth_cfg_t  synth_cfg_o;
    cal_status_t cal_status_o;
    int          err_total = 0, num_checks = 0, cyc = 0, sum;
    logic [31:0] rd;
    logic        er;
    typedef struct {logic [7:0] a; logic [31:0] rst, wd, ex; logic err;} reg_row_t;
    typedef struct {logic [3:0] ord; logic [31:0] num, den; int lo, hi;} mod_row_t;
    reg_row_t    regs[7] = '{
        '{`OFS_PRIMARY, 32'h00000064, 32'h0001ABCD, 32'h0000ABCD, 1'b0},
        '{`OFS_NUMER, 32'h0, 32'hFFFFFFFF, 32'h003FFFFF, 1'b0},
        '{`OFS_DENOM, 32'h1, 32'hFFFFFFFF, 32'h003FFFFF, 1'b0},
        '{`OFS_REFPATH, 32'h00100100, 32'h05100401, 32'h05100401, 1'b0},
        '{`OFS_OUTDIV, 32'h1, 32'hFFFFFFFF, 32'h0000003F, 1'b0},
        '{`OFS_CALSTART, 32'h00007F03, 32'h00000F04, 32'h00000F04, 1'b0},
        '{8'h20, 32'h0, 32'h00000001, 32'h0, 1'b1}};
    // numerator below denominator, integer mode for zero, dither on large den
    mod_row_t    mods[7] = '{'{4'h0, 1, 4, 0, 0}, '{4'h1, 1, 4, 99, 100},
        '{4'h2, 1, 4, 98, 101}, '{4'h3, 3, 8, 147, 153},
        '{4'h1, 32'h3FFFFE, 32'h3FFFFF, 398, 400}, '{4'h0, 0, 0, 0, 0},
        '{4'hD, 32'h200000, 32'h3FFFFF, 198, 201}};

    fractional_n_divider_control u_fractional_n_divider_control (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .apb_i(apb_i), .apb_o(apb_o), .divider_tick_i(divider_tick_i),
        .reference_input_i(reference_input_i), .vco_fast_i(vco_fast_i),
        .divide_value_o(divide_value_o), .synth_cfg_o(synth_cfg_o), .cal_status_o(cal_status_o));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock_i);
        apb_i.penable <= 1'b1;
        @(posedge clock_i);
        while (apb_o.pready !== 1'b1) @(posedge clock_i);
        rd = apb_o.prdata;
        er = apb_o.pslverr;
        apb_i <= '0;
    endtask

    // reference rises, each three clocks high and three low
    task automatic refp(input int n);
        repeat (n) begin
            repeat (3) @(posedge clock_i);
            reference_input_i <= 1'b1;
            repeat (3) @(posedge clock_i);
            reference_input_i <= 1'b0;
        end
    endtask

    initial begin
        apb_i = '0;
        sys_rst_i = 1'b1;
        divider_tick_i = 1'b0;
        reference_input_i = 1'b0;
        vco_fast_i = 1'b0;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(negedge clock_i);
        `CHK("divide reset", 17'h00064, divide_value_o)
        `CHK("cal reset", 12'h1FF, cal_status_o)
        // register table: reset value, write, read back, unmapped refusal
        foreach (regs[i]) begin
            apb(1'b0, regs[i].a, 32'h0);
            `CHK("reset read", regs[i].rst, rd)
            apb(1'b1, regs[i].a, regs[i].wd);
            apb(1'b0, regs[i].a, 32'h0);
            `CHK("read back", regs[i].ex, rd)
            `CHK("slverr", regs[i].err, er)
        end
        `CHK("ref path", {3'h5, 8'h10, 8'h04}, {synth_cfg_o.detector_delay_setting,
            synth_cfg_o.reference_frequency_setting, synth_cfg_o.reference_divide})
        `CHK("doubler", 1'b1, synth_cfg_o.reference_doubler_select)
        `CHK("out div", 6'h3F, synth_cfg_o.output_divide_value)
        $display("test registers done");
        // every order and dither code reaches the configuration
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `OFS_MODCTL, 32'(i));
            @(negedge clock_i);
            `CHK("order", 2'(i), synth_cfg_o.order)
            `CHK("dither", 2'(i >> 2), synth_cfg_o.dither)
        end
        $display("test modes done");
        // primary write restarts modulator, mean divide over 400 ticks
        foreach (mods[i]) begin
            apb(1'b1, `OFS_NUMER, mods[i].num);
            apb(1'b1, `OFS_DENOM, mods[i].den);
            apb(1'b1, `OFS_MODCTL, {28'h0, mods[i].ord});
            apb(1'b1, `OFS_PRIMARY, 32'h64);
            sum = 0;
            repeat (400) begin
                @(posedge clock_i);
                divider_tick_i <= 1'b1;
                @(posedge clock_i);
                divider_tick_i <= 1'b0;
                @(negedge clock_i);
                sum += int'(divide_value_o);
            end
            sum -= 40000;
            `CHK("fraction excess", 1'b1, sum >= mods[i].lo && sum <= mods[i].hi)
        end
        $display("test modulator done");
        // calibration from chosen start, stepped by reference rises
        apb(1'b1, `OFS_REFPATH, 32'h00020101);
        apb(1'b1, `OFS_PRIMARY, 32'h64);
        @(posedge clock_i);
        @(negedge clock_i);
        `CHK("cal start", 12'hA0F, {cal_status_o.busy, cal_status_o.done,
            cal_status_o.core, cal_status_o.tuning_capacitor_code})
        refp(3);
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("cal step", 7'h10, cal_status_o.tuning_capacitor_code)
        @(posedge clock_i);
        vco_fast_i <= 1'b1;
        refp(8);
        repeat (6) @(negedge clock_i);
        `CHK("cal done", 2'b01, {cal_status_o.busy, cal_status_o.done})
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("status", 32'h00011004, rd)
        $display("test calibration done");
        give_verdict();
    end
endmodule
`default_nettype wire
